// >>> src/ddc_decimation_filter_chain.sv
// five half-band decimate-by-two stages plus bypass path, complex I/Q
// assumes mode, boost and overrange inputs come from logic on i_clk_sys
`timescale 1ns/1ps

module halfband_stage #(
  parameter ddc_decim_pkg::coef_arr_t COEF  = '{default: '0},
  parameter int                       HALF  = 3,
  parameter int                       SHIFT = 5,
  parameter int                       OUTW  = 16
) (
  input  wire logic                                     i_clk_sys,  // sample clock
  input  wire logic                                     i_rst,      // async reset
  input  wire logic                                     i_en,       // stage in use
  input  wire logic                                     i_less,     // one bit less scaling
  input  wire logic                                     i_valid,    // input pair valid
  input  wire logic signed [ddc_decim_pkg::SAMPLE_W-1:0] i_i,       // in-phase in
  input  wire logic signed [ddc_decim_pkg::SAMPLE_W-1:0] i_q,       // quadrature in
  output logic                                          o_valid,    // output pair pulse
  output logic signed [ddc_decim_pkg::SAMPLE_W-1:0]     o_i,        // in-phase out
  output logic signed [ddc_decim_pkg::SAMPLE_W-1:0]     o_q         // quadrature out
);
  import ddc_decim_pkg::*;

  localparam int LAST = 2 * HALF;

  logic signed [SAMPLE_W-1:0] dl_reg [0:1][0:LAST];
  logic                       phase_reg;
  logic                       calc_reg;
  acc_t                       acc [0:1];
  int                         shift_now;

  // round half up, then clamp to the output width
  function automatic logic signed [SAMPLE_W-1:0] scale_sat(input acc_t a, input int sh);
    acc_t r;
    acc_t hi;
    acc_t lo;
    hi = (acc_t'(1) <<< (OUTW - 1)) - acc_t'(1);
    lo = -(acc_t'(1) <<< (OUTW - 1));
    r  = (a + (acc_t'(1) <<< (sh - 1))) >>> sh;
    if (r > hi) begin
      r = hi;
    end else if (r < lo) begin
      r = lo;
    end
    return r[SAMPLE_W-1:0];
  endfunction

  assign shift_now = SHIFT - int'(i_less);

  // symmetric FIR: pre-add mirrored taps, one product per pair
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      acc[c] = acc_t'(COEF[HALF]) * acc_t'(dl_reg[c][HALF]);
      for (int j = 0; j < HALF; j++) begin
        acc[c] = acc[c] + acc_t'(COEF[j]) *
                 (acc_t'(dl_reg[c][j]) + acc_t'(dl_reg[c][LAST-j]));
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k <= LAST; k++) begin
          dl_reg[c][k] <= '0;
        end
      end
    end else if (i_valid && i_en) begin
      dl_reg[0][0] <= i_i;
      dl_reg[1][0] <= i_q;
      for (int k = 1; k <= LAST; k++) begin
        dl_reg[0][k] <= dl_reg[0][k-1];
        dl_reg[1][k] <= dl_reg[1][k-1];
      end
    end
  end

  // keep every second input
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= 1'b0;
      calc_reg  <= 1'b0;
    end else if (!i_en) begin
      phase_reg <= 1'b0;
      calc_reg  <= 1'b0;
    end else begin
      if (i_valid) begin
        phase_reg <= ~phase_reg;
      end
      calc_reg <= i_valid && phase_reg;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_i     <= '0;
      o_q     <= '0;
    end else if (!i_en) begin
      // unused stage passes samples straight on
      o_valid <= i_valid;
      o_i     <= i_i;
      o_q     <= i_q;
    end else begin
      o_valid <= calc_reg;
      if (calc_reg) begin
        o_i <= scale_sat(acc[0], shift_now);
        o_q <= scale_sat(acc[1], shift_now);
      end
    end
  end
endmodule

module ddc_decimation_filter_chain (
  input  wire logic                                      i_clk_sys,    // sample clock
  input  wire logic                                      i_rst,        // async reset
  input  wire ddc_decim_pkg::decim_mode_e                i_decim_mode, // decimation setting
  input  wire logic                                      i_gain_boost, // 6.02 dB boost
  input  wire logic                                      i_valid,      // input sample valid
  input  wire logic signed [ddc_decim_pkg::SAMPLE_W-1:0] i_mix_i,      // mixer in-phase
  input  wire logic signed [ddc_decim_pkg::SAMPLE_W-1:0] i_mix_q,      // mixer quadrature
  input  wire logic [ddc_decim_pkg::REAL_W-1:0]          i_real,       // raw real sample
  input  wire logic                                      i_ovr_i,      // first threshold hit
  input  wire logic                                      i_ovr_q,      // second threshold hit
  output logic                                           o_cplx_valid, // complex pair pulse
  output logic [ddc_decim_pkg::SAMPLE_W-1:0]             o_word_i,     // I data and flag
  output logic [ddc_decim_pkg::SAMPLE_W-1:0]             o_word_q,     // Q data and flag
  output logic                                           o_real_valid, // bypass sample pulse
  output logic [ddc_decim_pkg::REAL_W-1:0]               o_real        // bypass real data
);
  import ddc_decim_pkg::*;

  logic                       en [1:5];
  logic                       v  [0:5];
  logic signed [SAMPLE_W-1:0] si [0:5];
  logic signed [SAMPLE_W-1:0] sq [0:5];
  logic                       bypass;
  logic                       overrange_flag_i_reg;
  logic                       overrange_flag_q_reg;

  // stage selection by decimation setting
  always_comb begin
    bypass = 1'b0;
    en[1]  = 1'b0;
    en[2]  = 1'b0;
    en[3]  = 1'b0;
    en[4]  = 1'b1;
    en[5]  = 1'b1;
    unique case (i_decim_mode)
      MODE_BYPASS: begin
        bypass = 1'b1;
        en[4]  = 1'b0;
        en[5]  = 1'b0;
      end
      MODE_DEC4: begin
      end
      MODE_DEC8: begin
        en[3] = 1'b1;
      end
      MODE_DEC16: begin
        en[2] = 1'b1;
        en[3] = 1'b1;
      end
      MODE_DEC32: begin
        en[1] = 1'b1;
        en[2] = 1'b1;
        en[3] = 1'b1;
      end
      default: begin
        bypass = 1'b1;
        en[4]  = 1'b0;
        en[5]  = 1'b0;
      end
    endcase
  end

  assign v[0]  = i_valid;
  assign si[0] = i_mix_i;
  assign sq[0] = i_mix_q;

  // stages in order of operation
  halfband_stage #(.COEF(COEF1), .HALF(HALF1), .SHIFT(SHIFT1), .OUTW(SAMPLE_W))
    halfband_stage_first (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(en[1]),
      .i_less(1'b0), .i_valid(v[0]), .i_i(si[0]), .i_q(sq[0]),
      .o_valid(v[1]), .o_i(si[1]), .o_q(sq[1]));
  halfband_stage #(.COEF(COEF2), .HALF(HALF2), .SHIFT(SHIFT2), .OUTW(SAMPLE_W))
    halfband_stage_second (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(en[2]),
      .i_less(1'b0), .i_valid(v[1]), .i_i(si[1]), .i_q(sq[1]),
      .o_valid(v[2]), .o_i(si[2]), .o_q(sq[2]));
  halfband_stage #(.COEF(COEF3), .HALF(HALF3), .SHIFT(SHIFT3), .OUTW(SAMPLE_W))
    halfband_stage_third (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(en[3]),
      .i_less(1'b0), .i_valid(v[2]), .i_i(si[2]), .i_q(sq[2]),
      .o_valid(v[3]), .o_i(si[3]), .o_q(sq[3]));
  halfband_stage #(.COEF(COEF4), .HALF(HALF4), .SHIFT(SHIFT4), .OUTW(SAMPLE_W))
    halfband_stage_fourth (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(en[4]),
      .i_less(1'b0), .i_valid(v[3]), .i_i(si[3]), .i_q(sq[3]),
      .o_valid(v[4]), .o_i(si[4]), .o_q(sq[4]));
  // boost halves the final scaling for +6.02 dB
  halfband_stage #(.COEF(COEF5), .HALF(HALF5), .SHIFT(SHIFT5_OUT), .OUTW(OUT_W))
    halfband_stage_fifth (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(en[5]),
      .i_less(i_gain_boost), .i_valid(v[4]), .i_i(si[4]), .i_q(sq[4]),
      .o_valid(v[5]), .o_i(si[5]), .o_q(sq[5]));

  // overrange hits gathered over one output interval, set wins over clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      overrange_flag_i_reg <= 1'b0;
      overrange_flag_q_reg <= 1'b0;
    end else if (v[5] && !bypass) begin
      overrange_flag_i_reg <= i_ovr_i;
      overrange_flag_q_reg <= i_ovr_q;
    end else begin
      overrange_flag_i_reg <= overrange_flag_i_reg | i_ovr_i;
      overrange_flag_q_reg <= overrange_flag_q_reg | i_ovr_q;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cplx_valid <= 1'b0;
      o_word_i     <= '0;
      o_word_q     <= '0;
    end else begin
      o_cplx_valid <= v[5] && !bypass;
      if (v[5] && !bypass) begin
        o_word_i <= {si[5][OUT_W-1:0], overrange_flag_i_reg | i_ovr_i};
        o_word_q <= {sq[5][OUT_W-1:0], overrange_flag_q_reg | i_ovr_q};
      end
    end
  end

  // bypass path: real samples at full rate, no filtering
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_real_valid <= 1'b0;
      o_real       <= '0;
    end else begin
      o_real_valid <= bypass && i_valid;
      if (bypass && i_valid) begin
        o_real <= i_real[REAL_LSB +: REAL_W];
      end
    end
  end
endmodule

// >>> src/ddc_decim_pkg.sv
// constants, coefficient sets and mode codes for the ddc decimation chain
// assumes one sample clock; mixer and threshold logic share that clock
// Overview of operation
// - every stage filters complex I/Q pairs; chain delivers 15-bit results.
// - each stage is a linear-phase FIR, giving constant group delay.
// - bypass does no filtering; a real 12-bit sample leaves for each valid input.
// - decimation N gives one complex output pair per N input samples.
// - factor selects stages: 4 uses fourth and fifth, each larger prepends one.
// - every stage decimates by two with its own power-of-two scale.
// - coefficients symmetric about one center tap; store half plus center.
// - first stage taps -1,0,9, center 16, scale 2^-5.
// - second stage taps -65,0,577, center 1024, scale 2^-11.
// - third stage taps 109,0,-837,0,4824, center 8192, scale 2^-14.
// - fourth stage taps -327..39742, center 65536, scale 2^-17.
// - fifth stage 27 half taps, center 262144, scale 2^-19.
// - composite response rejects stop band over 90 dB, ripple 0.001 dB.
// - protected pass band reaches 0.8 times clock rate over N.
// - gain boost set gives 6.02 dB chain gain, clear gives unity.
// - output word is 15 data bits above an overrange flag bit.
package ddc_decim_pkg;
  localparam int SAMPLE_W    = 16;
  localparam int OUT_W       = 15;
  localparam int REAL_W      = 12;
  localparam int COEF_W      = 20;
  localparam int ACC_W       = 48;
  localparam int MAX_HALF    = 28;
  localparam int REAL_LSB    = 0;

  typedef logic signed [COEF_W-1:0] coef_t;
  typedef coef_t                    coef_arr_t [0:MAX_HALF-1];
  typedef logic signed [ACC_W-1:0]  acc_t;

  typedef enum logic [2:0] {
    MODE_BYPASS = 3'h0,
    MODE_DEC4   = 3'h1,
    MODE_DEC8   = 3'h2,
    MODE_DEC16  = 3'h3,
    MODE_DEC32  = 3'h4
  } decim_mode_e;

  // half coefficient sets, center tap at index HALF
  // composite stop band and pass band rest on these sets alone
  localparam int        HALF1  = 3;
  localparam int        SHIFT1 = 5;
  localparam coef_arr_t COEF1  = '{0: -20'sh1, 2: 20'sh9, 3: 20'sh10, default: '0};
  localparam int        HALF2  = 3;
  localparam int        SHIFT2 = 11;
  localparam coef_arr_t COEF2  = '{0: -20'sh41, 2: 20'sh241, 3: 20'sh400, default: '0};
  localparam int        HALF3  = 5;
  localparam int        SHIFT3 = 14;
  localparam coef_arr_t COEF3  = '{0: 20'sh6d, 2: -20'sh345, 4: 20'sh12d8, 5: 20'sh2000,
                                   default: '0};
  localparam int        HALF4  = 7;
  localparam int        SHIFT4 = 17;
  localparam coef_arr_t COEF4  = '{0: -20'sh147, 2: 20'sh8b7, 4: -20'sh22b1, 6: 20'sh9b3e,
                                   7: 20'sh10000, default: '0};
  localparam int        HALF5  = 27;
  localparam int        SHIFT5 = 19;
  localparam coef_arr_t COEF5  = '{0: -20'sh25, 2: 20'sh76, 4: -20'sh123, 6: 20'sh264,
                                   8: -20'sh487, 10: 20'sh7ef, 12: -20'shd1c, 14: 20'sh14bc,
                                   16: -20'sh1fcc, 18: 20'sh2ffc, 20: -20'sh48c4,
                                   22: 20'sh730f, 24: -20'shcfc7, 26: 20'sh288ab,
                                   27: 20'sh40000, default: '0};
  // fifth stage drops one more bit to land on the 15-bit output
  localparam int        SHIFT5_OUT = SHIFT5 + SAMPLE_W - OUT_W;
endpackage

// >>> test/ddc_chain_props.sv
// checker on the top ports of the decimation chain
// assumes the mode is only changed while reset is held
`timescale 1ns/1ps
module ddc_chain_props
  import ddc_decim_pkg::*;
(
  input wire logic                   i_clk_sys,    // sample clock
  input wire logic                   i_rst,        // async reset
  input wire decim_mode_e            i_decim_mode, // decimation setting
  input wire logic                   i_valid,      // input valid
  input wire logic [REAL_W-1:0]      i_real,       // raw real sample
  input wire logic                   i_ovr_i,      // first threshold
  input wire logic                   i_ovr_q,      // second threshold
  input wire logic                   o_cplx_valid, // complex pulse
  input wire logic [SAMPLE_W-1:0]    o_word_i,     // I word
  input wire logic [SAMPLE_W-1:0]    o_word_q,     // Q word
  input wire logic                   o_real_valid, // bypass pulse
  input wire logic [REAL_W-1:0]      o_real        // bypass data
);
  logic [9:0] idle_reg;
  // cycles since the last input sample, saturating
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) idle_reg <= 10'h0;
    else if (i_valid) idle_reg <= 10'h0;
    else if (idle_reg != 10'h3ff) idle_reg <= idle_reg + 10'h1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_real_follows: assert property (i_valid && i_decim_mode == MODE_BYPASS |=>
    o_real_valid && o_real == $past(i_real)) else $error("bypass sample lost");
  a_real_quiet: assert property (!(i_valid && i_decim_mode == MODE_BYPASS) |=>
    !o_real_valid) else $error("bypass pulse without input");
  a_real_hold: assert property (!o_real_valid |-> $stable(o_real))
    else $error("real data moved between pulses");
  a_words_hold: assert property (!o_cplx_valid |-> $stable(o_word_i) && $stable(o_word_q))
    else $error("complex words moved between pulses");
  a_gap_four: assert property (o_cplx_valid && i_decim_mode == MODE_DEC4 |=>
    !o_cplx_valid [*3]) else $error("dec4 pulses too close");
  a_gap_eight: assert property (o_cplx_valid && i_decim_mode == MODE_DEC8 |=>
    !o_cplx_valid [*7]) else $error("dec8 pulses too close");
  a_flag_i_set: assert property (i_ovr_i ##1 o_cplx_valid |-> o_word_i[0])
    else $error("I overrange flag missing");
  a_flag_q_set: assert property (i_ovr_q ##1 o_cplx_valid |-> o_word_q[0])
    else $error("Q overrange flag missing");
  a_idle_quiet: assert property (idle_reg == 10'h3ff |-> !o_cplx_valid)
    else $error("complex output without input");
  c_dec32: cover property (o_cplx_valid && i_decim_mode == MODE_DEC32);
  c_bypass: cover property (o_real_valid);
  c_flag: cover property (o_cplx_valid && o_word_i[0]);
endmodule

bind ddc_decimation_filter_chain ddc_chain_props u_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_decim_mode(i_decim_mode), .i_valid(i_valid),
  .i_real(i_real), .i_ovr_i(i_ovr_i), .i_ovr_q(i_ovr_q), .o_cplx_valid(o_cplx_valid),
  .o_word_i(o_word_i), .o_word_q(o_word_q), .o_real_valid(o_real_valid), .o_real(o_real));

// >>> test/mixer_source.sv
// upstream mixer stand-in: steady or sign-alternating I/Q levels while running
// assumes run and levels change on falling edges
`timescale 1ns/1ps
module mixer_source (
  input  wire logic                                      i_clk_sys, // sample clock
  input  wire logic                                      i_run,     // stream on
  input  wire logic                                      i_alt,     // flip sign every sample
  input  wire logic signed [ddc_decim_pkg::SAMPLE_W-1:0] i_lvl_i,   // in-phase level
  input  wire logic signed [ddc_decim_pkg::SAMPLE_W-1:0] i_lvl_q,   // quadrature level
  output logic                                           o_valid,   // sample valid
  output logic signed [ddc_decim_pkg::SAMPLE_W-1:0]      o_i,       // in-phase sample
  output logic signed [ddc_decim_pkg::SAMPLE_W-1:0]      o_q        // quadrature sample
);
  initial begin
    o_valid = 1'b0;
    o_i = '0;
    o_q = '0;
  end
  // complex pairs every cycle; idle data flips so stale values cannot pass
  always @(negedge i_clk_sys) begin
    o_valid <= i_run;
    if (!i_run) begin
      o_i <= ~o_i;
      o_q <= ~o_q;
    end else if (i_alt && o_i == i_lvl_i) begin
      // tone at half the sample rate
      o_i <= -i_lvl_i;
      o_q <= -i_lvl_q;
    end else begin
      o_i <= i_lvl_i;
      o_q <= i_lvl_q;
    end
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the decimation chain
// assumes the mixer stand-in and the bound checker beside the design
`timescale 1ns/1ps
module tb_top;
  import ddc_decim_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, boost, run, alt, ovr_i, ovr_q, valid, cplx_valid, real_valid;
  decim_mode_e mode;
  logic signed [SAMPLE_W-1:0] lvl_i, lvl_q, mix_i, mix_q;
  logic [SAMPLE_W-1:0] word_i, word_q;
  logic [REAL_W-1:0] real_in, real_out;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int g;
  always #25 clk_sys = ~clk_sys;
  mixer_source u_src (.i_clk_sys(clk_sys), .i_run(run), .i_alt(alt), .i_lvl_i(lvl_i),
    .i_lvl_q(lvl_q), .o_valid(valid), .o_i(mix_i), .o_q(mix_q));
  ddc_decimation_filter_chain DUT (.i_clk_sys(clk_sys), .i_rst(rst), .i_decim_mode(mode),
    .i_gain_boost(boost), .i_valid(valid), .i_mix_i(mix_i), .i_mix_q(mix_q),
    .i_real(real_in), .i_ovr_i(ovr_i), .i_ovr_q(ovr_q), .o_cplx_valid(cplx_valid),
    .o_word_i(word_i), .o_word_q(word_q), .o_real_valid(real_valid), .o_real(real_out));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end
  task do_reset(input decim_mode_e m, input logic b);
    @(negedge clk_sys);
    rst <= 1'b1;
    run <= 1'b0;
    alt <= 1'b0;
    mode <= m;
    boost <= b;
    repeat (12) @(negedge clk_sys);
    rst <= 1'b0;
  endtask
  // cycles until the next complex pulse, bounded
  task wait_pulse(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cplx_valid !== 1'b1 && n < 3000);
  endtask
  task t_bypass;
    do_reset(MODE_BYPASS, 1'b0);
    run <= 1'b1;
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 6; k++) begin
      if (k > 0) chk({4'h0, real_out}, {4'h0, 12'h5a3 + 12'(k - 1) * 12'h111});
      if (k > 0) chk({15'h0, real_valid}, 16'h1);
      real_in <= 12'h5a3 + 12'(k) * 12'h111;
      @(negedge clk_sys);
    end
    chk({15'h0, cplx_valid}, 16'h0);
    $display("bypass test done");
  endtask
  task t_decim(input decim_mode_e m, input int n, input logic b, input logic [15:0] ei,
               input logic [15:0] eq);
    do_reset(m, b);
    lvl_i <= 16'sh2000;
    lvl_q <= -16'sh2000;
    run <= 1'b1;
    repeat (41) wait_pulse(g);
    wait_pulse(g);
    chk(16'(g), 16'(n));
    chk(word_i, ei);
    chk(word_q, eq);
    $display("decimate by %0d test done", n);
  endtask
  task t_saturate;
    do_reset(MODE_DEC4, 1'b1);
    lvl_i <= -16'sh8000;
    lvl_q <= 16'sh7fff;
    run <= 1'b1;
    repeat (42) wait_pulse(g);
    chk(word_i, 16'h8000);
    chk(word_q, 16'h7ffe);
    $display("saturation test done");
  endtask
  // half-rate tone must round away to zero at the output
  task t_stopband;
    do_reset(MODE_DEC4, 1'b0);
    lvl_i <= 16'sh2000;
    lvl_q <= 16'sh2000;
    alt <= 1'b1;
    run <= 1'b1;
    repeat (42) wait_pulse(g);
    chk(word_i, 16'h0000);
    chk(word_q, 16'h0000);
    $display("stop band test done");
  endtask
  task t_flags;
    do_reset(MODE_DEC4, 1'b0);
    lvl_i <= 16'sh2000;
    lvl_q <= 16'sh2000;
    run <= 1'b1;
    repeat (20) wait_pulse(g);
    ovr_i <= 1'b1;
    @(negedge clk_sys);
    ovr_i <= 1'b0;
    wait_pulse(g);
    chk({15'h0, word_i[0]}, 16'h1);
    chk({15'h0, word_q[0]}, 16'h0);
    ovr_q <= 1'b1;
    wait_pulse(g);
    ovr_q <= 1'b0;
    chk({15'h0, word_i[0]}, 16'h0);
    chk({15'h0, word_q[0]}, 16'h1);
    // hit in the output cycle also opens the next interval
    wait_pulse(g);
    chk({15'h0, word_q[0]}, 16'h1);
    wait_pulse(g);
    chk({15'h0, word_q[0]}, 16'h0);
    run <= 1'b0;
    repeat (1100) @(negedge clk_sys);
    chk({15'h0, cplx_valid}, 16'h0);
    $display("overrange flag test done");
  endtask
  initial begin
    rst = 1'b1;
    mode = MODE_BYPASS;
    boost = 1'b0;
    run = 1'b0;
    lvl_i = '0;
    lvl_q = '0;
    real_in = '0;
    ovr_i = 1'b0;
    ovr_q = 1'b0;
    alt = 1'b0;
    t_bypass();
    t_decim(MODE_DEC4, 4, 1'b0, 16'h2000, 16'he000);
    t_decim(MODE_DEC8, 8, 1'b1, 16'h4000, 16'hc000);
    t_decim(MODE_DEC16, 16, 1'b0, 16'h2000, 16'he000);
    t_decim(MODE_DEC32, 32, 1'b1, 16'h4000, 16'hc000);
    t_saturate();
    t_stopband();
    t_flags();
    results();
  end
endmodule
